/* File: core/fram_host_pkg.sv */
// Constants and types for the host port controller of the non-volatile RAM
package fram_host_pkg;

	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DATA_W = 16;
	localparam int LANES = 2;
	localparam int LANE_W = 8;
	localparam int ROW_W = 14;
	localparam int COL_W = 2;
	localparam int ADDR_W = ROW_W + COL_W;
	localparam int TIMER_W = 16;

	// ----------------------------------------
	// Timing in its own units
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int T_CA_NS = 70;
	localparam int T_CW_NS = 70;
	localparam int T_PC_NS = 35;
	localparam int T_AA_NS = 105;
	localparam int T_AAP_NS = 40;
	localparam int T_PAGE_HOLD_NS = 15;
	localparam int T_ZZL_NS = 1000;
	localparam int T_PU_MS = 1;
	localparam int T_ZZEX_US = 500;

	// ----------------------------------------
	// Cycle counts, least times rounded up
	// ----------------------------------------
	localparam int T_CA_CYC = (T_CA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_WE_LOW_CYC = (T_CW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_PC_CYC = (T_PC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_AA_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_AAP_CYC = (T_AAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_PAGE_HOLD_CYC = (T_PAGE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_ZZL_CYC = (T_ZZL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_PU_CYC = (T_PU_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int T_ZZEX_CYC = (T_ZZEX_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SAMPLE_MARGIN_CYC = 1;

	// ----------------------------------------
	// Values after reset
	// ----------------------------------------
	localparam logic PIN_INACTIVE = 1'b1;
	localparam logic [LANES-1:0] LANES_OFF = 2'h3;

	// ----------------------------------------
	// Controller states
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_POWERUP,
		ST_IDLE,
		ST_OPEN,
		ST_READ,
		ST_WRITE_LOW,
		ST_WRITE_REC,
		ST_PRECHARGE,
		ST_SLEEP,
		ST_WAKE
	} state_t;

endpackage

/* File: core/fram_wait_timer.sv */
// Loadable down counter that paces the pin sequences
`timescale 1ns/100ps
module fram_wait_timer #(
	parameter logic [fram_host_pkg::TIMER_W-1:0] RESET_COUNT = 16'h0000
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic load_i,
	input wire logic [fram_host_pkg::TIMER_W-1:0] count_i,
	output logic done_o
);

	typedef struct packed {
		logic [fram_host_pkg::TIMER_W-1:0] count;
	} timer_state_t;

	timer_state_t s;
	timer_state_t next_s;

	always_comb begin
		next_s = s;
		if (load_i) begin
			next_s.count = count_i;
		end else if (s.count != '0) begin
			next_s.count = s.count - 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s.count <= RESET_COUNT;
		end else begin
			s <= next_s;
		end
	end

	assign done_o = (s.count == '0);

endmodule // fram_wait_timer

/* File: core/fram_host_ctrl.sv */
// Host controller driving the pins of an asynchronous non-volatile RAM
// Notes on behaviour
// R1 - Device latches write data on first rising strobe.
// R2 - Strobe write starts as read, latches row.
// R3 - Host holds column address stable 15 ns.
// R4 - Page reads may visit columns in any order.
// R5 - Lane selects tied only without byte writes.
// R6 - High lane write keeps low byte.
// R7 - Low lane write keeps high byte; both whole.
// R8 - High lane read floats low byte lines.
// R9 - Low lane read floats high; none disables.
// R10 - Chip select active at least 70 ns.
// R11 - Write strobe low at least 22 ns.
// R12 - Page write strobes spaced at least 40 ns.
// R13 - Strobe low 30 ns before chip deselect.
// R14 - Row stable 30 ns after strobe falls.
// R15 - Device floats outputs 10 ns after strobe.
// R16 - Wait 1 ms after power before access.
// R17 - Device floats bus 20 ns into sleep.
// R18 - Wait 500 us after sleep exit.
// R19 - Chip select don't-care once sleep asserted.
// R20 - Device ignores all pins while sleeping.
// R21 - Row change forces precharge then new row.
// R22 - Address change starts access under chip select.
// R23 - Array is 16K rows of four words.
// R24 - High lane is bits 15-8, low 7-0.
`timescale 1ns/100ps
module fram_host_ctrl #(
	parameter int PU_CYCLES = fram_host_pkg::T_PU_CYC,
	parameter int ZZEX_CYCLES = fram_host_pkg::T_ZZEX_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic req_i,
	input wire logic write_i,
	input wire logic [fram_host_pkg::ADDR_W-1:0] addr_i,
	input wire logic [fram_host_pkg::DATA_W-1:0] wdata_i,
	input wire logic [fram_host_pkg::LANES-1:0] byte_en_i,
	input wire logic sleep_i,
	output logic ready_o,
	output logic done_o,
	output logic rvalid_o,
	output logic [fram_host_pkg::DATA_W-1:0] rdata_o,
	output logic asleep_o,
	output logic chip_sel_n_o,
	output logic write_en_n_o,
	output logic out_en_n_o,
	output logic high_lane_sel_n_o,
	output logic low_lane_sel_n_o,
	output logic sleep_request_n_o,
	output logic [fram_host_pkg::ROW_W-1:0] row_address_o,
	output logic [fram_host_pkg::COL_W-1:0] column_address_o,
	input wire logic [fram_host_pkg::DATA_W-1:0] dq_i,
	output logic [fram_host_pkg::DATA_W-1:0] dq_o,
	output logic [fram_host_pkg::LANES-1:0] dq_oe_n_o
);

	typedef struct packed {
		fram_host_pkg::state_t state;
		logic cs_n;
		logic we_n;
		logic oe_n;
		logic [fram_host_pkg::LANES-1:0] lane_n;
		logic zz_n;
		logic [fram_host_pkg::ROW_W-1:0] row;
		logic [fram_host_pkg::COL_W-1:0] col;
		logic [fram_host_pkg::DATA_W-1:0] dq_out;
		logic [fram_host_pkg::LANES-1:0] dq_oe_n;
		logic [fram_host_pkg::DATA_W-1:0] rdata;
		logic rvalid;
		logic done;
		logic ready;
		logic asleep;
	} ctrl_state_t;

	ctrl_state_t s;
	ctrl_state_t next_s;
	logic t_load;
	logic [fram_host_pkg::TIMER_W-1:0] t_val;
	logic t_done;
	logic [fram_host_pkg::ROW_W-1:0] req_row;
	logic [fram_host_pkg::COL_W-1:0] req_col;
	logic [fram_host_pkg::DATA_W-1:0] lane_data;

	assign req_row = addr_i[fram_host_pkg::ADDR_W-1:fram_host_pkg::COL_W];
	assign req_col = addr_i[fram_host_pkg::COL_W-1:0];

	// ----------------------------------------
	// Interval timer
	// ----------------------------------------
	fram_wait_timer #(
		.RESET_COUNT(fram_host_pkg::TIMER_W'(PU_CYCLES - 1))
	) u_timer (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.load_i(t_load),
		.count_i(t_val),
		.done_o(t_done)
	);

	// ----------------------------------------
	// Read lane masking
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < fram_host_pkg::LANES; g++) begin : g_lane
			// R24 lane to data bits
			assign lane_data[g*fram_host_pkg::LANE_W +: fram_host_pkg::LANE_W] =
				s.lane_n[g] ? '0 : dq_i[g*fram_host_pkg::LANE_W +: fram_host_pkg::LANE_W];
		end
	endgenerate

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_comb begin
		next_s = s;
		next_s.rvalid = 1'b0;
		next_s.done = 1'b0;
		t_load = 1'b0;
		t_val = '0;
		unique case (s.state)
			fram_host_pkg::ST_POWERUP: begin
				// R16 power-up quiet time
				if (t_done) begin
					next_s.state = fram_host_pkg::ST_IDLE;
					next_s.ready = 1'b1;
				end
			end
			fram_host_pkg::ST_IDLE, fram_host_pkg::ST_OPEN: begin
				if (s.state == fram_host_pkg::ST_IDLE && sleep_i) begin
					// R19 deselect before sleep
					next_s.cs_n = 1'b1;
					next_s.zz_n = 1'b0;
					next_s.ready = 1'b0;
					next_s.asleep = 1'b1;
					t_load = 1'b1;
					t_val = fram_host_pkg::TIMER_W'(fram_host_pkg::T_ZZL_CYC - 1);
					next_s.state = fram_host_pkg::ST_SLEEP;
				end else if (s.state == fram_host_pkg::ST_OPEN &&
					(sleep_i || (req_i && req_row != s.row))) begin
					// R21 close row before new one
					next_s.cs_n = 1'b1;
					next_s.oe_n = 1'b1;
					next_s.ready = 1'b0;
					t_load = 1'b1;
					t_val = fram_host_pkg::TIMER_W'(fram_host_pkg::T_PC_CYC - 1);
					next_s.state = fram_host_pkg::ST_PRECHARGE;
				end else if (req_i) begin
					// R10 R22 new access, chip held selected
					next_s.cs_n = 1'b0;
					next_s.row = req_row;
					// R3 R4 column held, any order
					next_s.col = req_col;
					// R5 lanes follow every request
					next_s.lane_n = ~byte_en_i;
					next_s.ready = 1'b0;
					t_load = 1'b1;
					if (write_i) begin
						// R2 R14 strobe write with row set
						next_s.we_n = 1'b0;
						next_s.oe_n = 1'b1;
						next_s.dq_out = wdata_i;
						next_s.dq_oe_n = ~byte_en_i;
						// R11 R13 strobe low two cycles
						t_val = fram_host_pkg::TIMER_W'(fram_host_pkg::T_WE_LOW_CYC - 1);
						next_s.state = fram_host_pkg::ST_WRITE_LOW;
					end else begin
						next_s.oe_n = 1'b0;
						if (s.state == fram_host_pkg::ST_OPEN) begin
							t_val = fram_host_pkg::TIMER_W'(fram_host_pkg::T_AAP_CYC +
								fram_host_pkg::SAMPLE_MARGIN_CYC - 1);
						end else begin
							t_val = fram_host_pkg::TIMER_W'(fram_host_pkg::T_AA_CYC +
								fram_host_pkg::SAMPLE_MARGIN_CYC - 1);
						end
						next_s.state = fram_host_pkg::ST_READ;
					end
				end
			end
			fram_host_pkg::ST_READ: begin
				// R8 R9 only selected lanes kept
				if (t_done) begin
					next_s.rdata = lane_data;
					next_s.rvalid = 1'b1;
					next_s.done = 1'b1;
					next_s.ready = 1'b1;
					next_s.state = fram_host_pkg::ST_OPEN;
				end
			end
			fram_host_pkg::ST_WRITE_LOW: begin
				// R1 rising strobe ends the write
				if (t_done) begin
					next_s.we_n = 1'b1;
					next_s.state = fram_host_pkg::ST_WRITE_REC;
				end
			end
			fram_host_pkg::ST_WRITE_REC: begin
				// R12 strobe high a full cycle
				next_s.dq_oe_n = fram_host_pkg::LANES_OFF;
				next_s.done = 1'b1;
				next_s.ready = 1'b1;
				next_s.state = fram_host_pkg::ST_OPEN;
			end
			fram_host_pkg::ST_PRECHARGE: begin
				if (t_done) begin
					next_s.ready = 1'b1;
					next_s.state = fram_host_pkg::ST_IDLE;
				end
			end
			fram_host_pkg::ST_SLEEP: begin
				if (t_done && !sleep_i) begin
					next_s.zz_n = 1'b1;
					t_load = 1'b1;
					t_val = fram_host_pkg::TIMER_W'(ZZEX_CYCLES - 1);
					next_s.state = fram_host_pkg::ST_WAKE;
				end
			end
			fram_host_pkg::ST_WAKE: begin
				// R18 wake-up delay
				if (t_done) begin
					next_s.asleep = 1'b0;
					next_s.ready = 1'b1;
					next_s.state = fram_host_pkg::ST_IDLE;
				end
			end
			default: begin
				next_s.state = fram_host_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s.state <= fram_host_pkg::ST_POWERUP;
			s.cs_n <= fram_host_pkg::PIN_INACTIVE;
			s.we_n <= fram_host_pkg::PIN_INACTIVE;
			s.oe_n <= fram_host_pkg::PIN_INACTIVE;
			s.lane_n <= fram_host_pkg::LANES_OFF;
			s.zz_n <= fram_host_pkg::PIN_INACTIVE;
			s.row <= '0;
			s.col <= '0;
			s.dq_out <= '0;
			s.dq_oe_n <= fram_host_pkg::LANES_OFF;
			s.rdata <= '0;
			s.rvalid <= 1'b0;
			s.done <= 1'b0;
			s.ready <= 1'b0;
			s.asleep <= 1'b0;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign ready_o = s.ready;
	assign done_o = s.done;
	assign rvalid_o = s.rvalid;
	assign rdata_o = s.rdata;
	assign asleep_o = s.asleep;
	assign chip_sel_n_o = s.cs_n;
	assign write_en_n_o = s.we_n;
	assign out_en_n_o = s.oe_n;
	assign high_lane_sel_n_o = s.lane_n[1];
	assign low_lane_sel_n_o = s.lane_n[0];
	assign sleep_request_n_o = s.zz_n;
	assign row_address_o = s.row;
	assign column_address_o = s.col;
	assign dq_o = s.dq_out;
	assign dq_oe_n_o = s.dq_oe_n;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	logic [fram_host_pkg::TIMER_W-1:0] quiet_cnt;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			quiet_cnt <= fram_host_pkg::TIMER_W'(PU_CYCLES);
		end else if (!s.zz_n && next_s.zz_n) begin
			quiet_cnt <= fram_host_pkg::TIMER_W'(ZZEX_CYCLES);
		end else if (quiet_cnt != '0) begin
			quiet_cnt <= quiet_cnt - 1'b1;
		end
	end

	a_cs_active_min: assert property ($rose(chip_sel_n_o) |->   // R10
		!$past(chip_sel_n_o, 1) && !$past(chip_sel_n_o, 2))
		else $error("chip select active too short");
	a_we_pulse_min: assert property ($fell(write_en_n_o) |=> !write_en_n_o)   // R11
		else $error("write strobe pulse too short");
	a_we_gap: assert property ($rose(write_en_n_o) |=> write_en_n_o)   // R12
		else $error("write strobes too close");
	a_we_before_cs: assert property ($rose(chip_sel_n_o) |->   // R13
		$past(write_en_n_o, 1) && $past(write_en_n_o, 2))
		else $error("chip deselected during write strobe");
	a_row_hold_write: assert property (!write_en_n_o |=> $stable(row_address_o))   // R14
		else $error("row changed during write");
	a_col_hold: assert property ($changed(column_address_o) |=>   // R3
		$stable(column_address_o))
		else $error("column address not held");
	a_quiet_access: assert property (quiet_cnt != '0 |-> chip_sel_n_o)   // R16 R18
		else $error("access during power-up or wake delay");
	a_sleep_deselect: assert property (!sleep_request_n_o |->   // R19
		chip_sel_n_o && write_en_n_o)
		else $error("chip selected while sleeping");
	a_write_lanes: assert property (!write_en_n_o |->   // R7
		dq_oe_n_o == {high_lane_sel_n_o, low_lane_sel_n_o})
		else $error("write data lanes do not match selects");
	a_no_contention: assert property (!out_en_n_o |->   // R9
		dq_oe_n_o == fram_host_pkg::LANES_OFF)
		else $error("bus driven while device may drive");
	a_read_latency: assert property ($rose(rvalid_o) |->   // R22
		!$past(chip_sel_n_o, 1) && !$past(out_en_n_o, 1))
		else $error("read data taken without active read");

	c_page_read: cover property (rvalid_o ##[2:4] rvalid_o);
	c_page_write: cover property ($rose(write_en_n_o) ##[1:4] $fell(write_en_n_o));
	c_sleep_cycle: cover property ($fell(sleep_request_n_o) ##[1:40] $rose(sleep_request_n_o));
	c_col_jump: cover property (column_address_o == 2'h3 ##[1:8] column_address_o == 2'h0
		&& !chip_sel_n_o);

endmodule // fram_host_ctrl

/* File: tb/fram_dev_model.sv */
// Behavioural model of the non-volatile RAM seen from its pins
`timescale 1ns/100ps
module fram_dev_model #(
	parameter int ACC_NS = 30
) (
	input wire logic chip_sel_n_i,
	input wire logic write_en_n_i,
	input wire logic out_en_n_i,
	input wire logic high_lane_sel_n_i,
	input wire logic low_lane_sel_n_i,
	input wire logic sleep_request_n_i,
	input wire logic [13:0] row_address_i,
	input wire logic [1:0] column_address_i,
	input wire logic [15:0] dq_i,
	output logic [15:0] dq_o
);
	// row and column form the word address
	logic [15:0] mem [0:65535];
	logic [15:0] rd;
	logic [15:0] last = 16'h5A5A;
	logic armed = 1'b0;
	logic cond;
	logic slow;
	logic [1:0] en;
	wire [15:0] addr = {row_address_i, column_address_i};
	// ----------------------------------------
	// Write capture
	// ----------------------------------------
	// arm only when awake
	always @(negedge write_en_n_i or negedge chip_sel_n_i) begin
		armed = !write_en_n_i && !chip_sel_n_i && sleep_request_n_i;
	end
	always @(posedge write_en_n_i or posedge chip_sel_n_i) begin
		if (armed) begin
			if (!high_lane_sel_n_i) mem[addr][15:8] = dq_i[15:8];
			if (!low_lane_sel_n_i) mem[addr][7:0] = dq_i[7:0];
		end
		armed = 1'b0;
	end
	// ----------------------------------------
	// Read drive
	// ----------------------------------------
	// any address change starts a new access
	assign #ACC_NS rd = mem[addr];
	assign cond = !chip_sel_n_i && write_en_n_i && !out_en_n_i && sleep_request_n_i;
	assign #ACC_NS slow = cond;
	// lanes on late, off at once
	assign en = (cond && slow) ? ~{high_lane_sel_n_i, low_lane_sel_n_i} : 2'h0;
	always @(rd or en) begin
		if (en[1]) last[15:8] = rd[15:8];
		if (en[0]) last[7:0] = rd[7:0];
	end
	assign dq_o = {en[1] ? rd[15:8] : ~last[15:8], en[0] ? rd[7:0] : ~last[7:0]};
endmodule // fram_dev_model

/* File: tb/testbench.sv */
// Self-checking bench for the host controller with a device model
`timescale 1ns/100ps
module testbench;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic req_i = 1'b0;
	logic write_i = 1'b0;
	logic sleep_i = 1'b0;
	logic [15:0] addr_i = 16'h0000;
	logic [15:0] wdata_i = 16'h0000;
	logic [1:0] byte_en_i = 2'h0;
	logic ready_o, done_o, rvalid_o, asleep_o, cs_n, we_n, oe_n, hi_n, lo_n, zz_n;
	logic [15:0] rdata_o, dq_i, dq_o, dev_q;
	logic [1:0] dq_oe_n_o;
	logic [13:0] row;
	logic [1:0] col;
	logic [15:0] ref_mem [int];
	logic [15:0] exp_q [$];
	logic [1:0] cols [4] = '{2'h3, 2'h0, 2'h2, 2'h1};
	logic row_open = 1'b0;
	logic [13:0] open_row = 14'h0000;
	int num_errors = 0;
	int total_checks = 0;
	int acc_cnt = 0;
	int done_cnt = 0;
	int seed = 32'h92e6;
	int n;

	always #20 clk_i = ~clk_i;
	assign dq_i[15:8] = (dq_oe_n_o[1] === 1'b0) ? dq_o[15:8] : dev_q[15:8];
	assign dq_i[7:0] = (dq_oe_n_o[0] === 1'b0) ? dq_o[7:0] : dev_q[7:0];

	fram_host_ctrl #(.PU_CYCLES(20), .ZZEX_CYCLES(10)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.req_i(req_i), .write_i(write_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.byte_en_i(byte_en_i), .sleep_i(sleep_i), .ready_o(ready_o), .done_o(done_o),
		.rvalid_o(rvalid_o), .rdata_o(rdata_o), .asleep_o(asleep_o), .chip_sel_n_o(cs_n),
		.write_en_n_o(we_n), .out_en_n_o(oe_n), .high_lane_sel_n_o(hi_n),
		.low_lane_sel_n_o(lo_n), .sleep_request_n_o(zz_n), .row_address_o(row),
		.column_address_o(col), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o));
	fram_dev_model dev (.chip_sel_n_i(cs_n), .write_en_n_i(we_n), .out_en_n_i(oe_n),
		.high_lane_sel_n_i(hi_n), .low_lane_sel_n_i(lo_n), .sleep_request_n_i(zz_n),
		.row_address_i(row), .column_address_i(col), .dq_i(dq_i), .dq_o(dev_q));

	// ----------------------------------------
	// Checking and closing
	// ----------------------------------------
	task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic timed_out;
		num_errors++;
		$display("MISMATCH wait expected ready seen timeout");
		results();
	endtask

	// Request waits for take; row change costs a precharge first
	task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d,
		input logic [1:0] be);
		int k;
		req_i = 1'b1;
		write_i = wr;
		addr_i = a;
		wdata_i = d;
		byte_en_i = be;
		for (k = 0; !(ready_o === 1'b1 && !(row_open && open_row != a[15:2])); k++) begin
			if (ready_o === 1'b1) row_open = 1'b0;
			if (k > 100) timed_out();
			@(negedge clk_i);
		end
		row_open = 1'b1;
		acc_cnt++;
		open_row = a[15:2];
		if (wr && be[1]) ref_mem[a][15:8] = d[15:8];
		if (wr && be[0]) ref_mem[a][7:0] = d[7:0];
		if (!wr) exp_q.push_back({be[1] ? ref_mem[a][15:8] : 8'h00,
			be[0] ? ref_mem[a][7:0] : 8'h00});
		@(negedge clk_i);
	endtask

	task automatic wait_ready;
		int k;
		req_i = 1'b0;
		for (k = 0; ready_o !== 1'b1 || exp_q.size() > 0; k++) begin
			if (k > 100) timed_out();
			@(negedge clk_i);
		end
	endtask

	always @(negedge clk_i) begin
		if (done_o === 1'b1) done_cnt++;
		if (rvalid_o === 1'b1) begin
			if (exp_q.size() == 0) check("unexpected read", 16'h0000, 16'hFFFF);
			else check("read data", exp_q.pop_front(), rdata_o);
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(negedge clk_i);
		rst_n_i = 1'b1;
		for (n = 0; ready_o !== 1'b1; n++) begin
			if (n > 100) timed_out();
			@(negedge clk_i);
		end
		check("power-up wait", {15'h0000, n >= 19}, 16'h0001);
		for (n = 0; n < 4; n++) access(1'b1, {14'h0005, 2'(n)}, 16'($random(seed)), 2'h3);
		for (n = 0; n < 4; n++) access(1'b0, {14'h0005, cols[n]}, 16'h0000, 2'h3);
		access(1'b1, 16'h0014, 16'($random(seed)), 2'h2);
		access(1'b1, 16'h0015, 16'($random(seed)), 2'h1);
		for (n = 0; n < 4; n++) begin
			access(1'b0, 16'h0014, 16'h0000, 2'(n));
			access(1'b0, 16'h0015, 16'h0000, 2'(n));
		end
		access(1'b1, 16'hFFFF, 16'($random(seed)), 2'h3);
		access(1'b0, 16'h0016, 16'h0000, 2'h3);
		access(1'b0, 16'hFFFF, 16'h0000, 2'h3);
		access(1'b1, 16'hFFFC, 16'($random(seed)), 2'h3);
		access(1'b0, 16'hFFFC, 16'h0000, 2'h3);
		wait_ready();
		sleep_i = 1'b1;
		for (n = 0; asleep_o !== 1'b1; n++) begin
			if (n > 100) timed_out();
			@(negedge clk_i);
		end
		repeat (30) @(negedge clk_i);
		check("ready asleep", {15'h0000, ready_o}, 16'h0000);
		row_open = 1'b0;
		sleep_i = 1'b0;
		for (n = 0; ready_o !== 1'b1; n++) begin
			if (n > 100) timed_out();
			@(negedge clk_i);
		end
		check("wake wait", {15'h0000, n >= 10}, 16'h0001);
		access(1'b0, 16'h0014, 16'h0000, 2'h3);
		access(1'b0, 16'hFFFF, 16'h0000, 2'h3);
		wait_ready();
		check("done pulses", 16'(acc_cnt), 16'(done_cnt));
		results();
	end
endmodule // testbench
